//--- hdl/drc_pkg.sv
// constants, types and register map of the disturbance recorder control
// assumes a 250 MHz system clock and a 32-bit APB register bus
`default_nettype none

package drc_pkg;

	// ==========================================================
	// register offsets (byte addresses)
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_TRIG_SEL = 8'h04;
	localparam logic [7:0] OFF_CMD = 8'h08;
	localparam logic [7:0] OFF_CLR_IDX = 8'h0C;
	localparam logic [7:0] OFF_REC_LEN = 8'h10;
	localparam logic [7:0] OFF_PRE_LEN = 8'h14;
	localparam logic [7:0] OFF_CHAN_CNT = 8'h18;
	localparam logic [7:0] OFF_STATUS = 8'h1C;
	localparam logic [7:0] OFF_MAX_NUM = 8'h20;
	localparam logic [7:0] OFF_MAX_LEN = 8'h24;
	localparam logic [7:0] OFF_MAX_PRE = 8'h28;
	localparam logic [7:0] OFF_REC_CNT = 8'h2C;

	// ==========================================================
	// field positions
	localparam int CMD_MANUAL = 0;
	localparam int CMD_CLR_ALL = 1;
	localparam int CMD_CLR_NEW = 2;
	localparam int CMD_CLR_OLD = 3;
	localparam int CHAN_ANA_LSB = 0;
	localparam int CHAN_DIG_LSB = 8;

	// ==========================================================
	// reset values and limits (times in ms)
	localparam logic [31:0] LEN_DEF = 32'h0000_03E8;
	localparam logic [31:0] LEN_MIN = 32'h0000_0064;
	localparam logic [31:0] LEN_MAX = 32'h001B_7740;
	localparam logic [31:0] PRE_DEF = 32'h0000_00C8;
	localparam logic [31:0] PRE_MIN = 32'h0000_00C8;
	localparam logic [31:0] PRE_MAX = 32'h0000_3A98;
	localparam logic [6:0] MAX_RECS = 7'h64;
	localparam logic [7:0] ANA_MAX = 8'h14;
	localparam logic [7:0] DIG_MAX = 8'h5F;
	localparam int FN_HZ = 50;
	localparam int DIG_HZ = 200;
	localparam int MEM_WORDS = 16076647;
	localparam int STORE_CYC = 16;

	// ==========================================================
	// timing
	localparam int CLK_PERIOD_NS = 4;
	localparam int MS_NS = 1000000;
	localparam int MS_CYC = MS_NS / CLK_PERIOD_NS;
	localparam logic [2:0] DIG_MS = 3'h5;

	// ==========================================================
	// types
	typedef enum logic [6:0] {
		ST_OFF = 7'h01,
		ST_READY = 7'h02,
		ST_TRIG = 7'h04,
		ST_RECSTORE = 7'h08,
		ST_STORING = 7'h10,
		ST_FULL = 7'h20,
		ST_WRONG = 7'h40
	} drc_state_t;

	// rate: 0=64, 1=32, 2=16, 3=8 samples per cycle
	typedef struct packed {
		logic [1:0] rate;
		logic keep;
		logic enable;
	} drc_ctrl_t;

	typedef struct packed {
		logic valid;
		logic dropped;
		logic [6:0] slot;
		logic [15:0] seq;
	} drc_commit_t;

endpackage

`default_nettype wire

//--- hdl/drc_top.sv
// disturbance recorder control: arming, triggering, capture timing, store bookkeeping
// assumes synchronous inputs and a per-sample strobe from the measurement at 64 s/c
`default_nettype none

module drc_top #(
	parameter int NSIG = 32,
	parameter int MS_CYC = drc_pkg::MS_CYC,
	parameter int MEM_WORDS = drc_pkg::MEM_WORDS,
	parameter int STORE_CYC = drc_pkg::STORE_CYC
) (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// measurement side
	input wire logic [NSIG-1:0] binary_sig,
	input wire logic ana_strobe,
	output logic ana_take,
	output logic dig_take,
	output logic pre_full,
	output drc_pkg::drc_commit_t commit,
	output drc_pkg::drc_state_t rec_state
);

	// elaboration check of the parameters the logic can serve
	if (NSIG < 1 || NSIG > 32 || MS_CYC < 1 || STORE_CYC < 1 || MEM_WORDS < 1) begin : g_bad_param
		$error("drc_top: unsupported parameter value");
	end

	// ==========================================================
	// reset release
	logic rst_q1;
	logic rst_n_s;

	// two-stage release of the async reset
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rst_q1 <= 1'b0;
			rst_n_s <= 1'b0;
		end else begin
			rst_q1 <= 1'b1;
			rst_n_s <= rst_q1;
		end
	end

	// ==========================================================
	// register bus
	drc_pkg::drc_ctrl_t ctrl;
	logic [NSIG-1:0] trig_sel;
	logic [31:0] len_ms;
	logic [31:0] pre_ms;
	logic [7:0] ana_n;
	logic [7:0] dig_n;
	logic [31:0] clr_idx;
	logic [31:0] max_len;
	logic [6:0] max_num;
	logic [6:0] count;
	logic man_req;
	logic pend_all;
	logic pend_new;
	logic pend_old;
	logic pend_idx;
	logic [31:0] rd_val;
	logic mapped;
	logic wr_en;
	logic wr_cmd;
	logic [2:0] st_code;
	logic [31:0] max_pre;

	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped;
	assign wr_en = psel && penable && pwrite && mapped;
	assign wr_cmd = wr_en && paddr == drc_pkg::OFF_CMD;

	// read mux and address decode
	always_comb begin
		rd_val = 32'h0000_0000;
		mapped = 1'b1;
		case (paddr)
			drc_pkg::OFF_CTRL: rd_val = {28'h0000_000, ctrl};
			drc_pkg::OFF_TRIG_SEL: rd_val = 32'(trig_sel);
			drc_pkg::OFF_CMD: rd_val = {28'h0000_000, pend_old, pend_new, pend_all, man_req};
			drc_pkg::OFF_CLR_IDX: rd_val = clr_idx;
			drc_pkg::OFF_REC_LEN: rd_val = len_ms;
			drc_pkg::OFF_PRE_LEN: rd_val = pre_ms;
			drc_pkg::OFF_CHAN_CNT: rd_val = {16'h0000, dig_n, ana_n};
			drc_pkg::OFF_STATUS: rd_val = {29'h0000_0000, st_code};
			drc_pkg::OFF_MAX_NUM: rd_val = {25'h000_0000, max_num};
			drc_pkg::OFF_MAX_LEN: rd_val = max_len;
			drc_pkg::OFF_MAX_PRE: rd_val = max_pre;
			drc_pkg::OFF_REC_CNT: rd_val = {25'h000_0000, count};
			default: mapped = 1'b0;
		endcase
	end

	// read data captured in the setup cycle
	always_ff @(posedge clk or negedge rst_n_s) begin
		if (!rst_n_s) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable) begin
			prdata <= rd_val;
		end
	end

	// settings written by software
	always_ff @(posedge clk or negedge rst_n_s) begin
		if (!rst_n_s) begin
			ctrl <= '0;
			trig_sel <= '0;
			len_ms <= drc_pkg::LEN_DEF;
			pre_ms <= drc_pkg::PRE_DEF;
			ana_n <= 8'h00;
			dig_n <= 8'h00;
			clr_idx <= 32'h0000_0000;
		end else if (wr_en) begin
			case (paddr)
				drc_pkg::OFF_CTRL: ctrl <= pwdata[3:0];
				drc_pkg::OFF_TRIG_SEL: trig_sel <= pwdata[NSIG-1:0];
				drc_pkg::OFF_CLR_IDX: clr_idx <= pwdata;
				drc_pkg::OFF_REC_LEN: len_ms <= pwdata;
				drc_pkg::OFF_PRE_LEN: pre_ms <= pwdata;
				drc_pkg::OFF_CHAN_CNT: begin
					ana_n <= pwdata[drc_pkg::CHAN_ANA_LSB +: 8];
					dig_n <= pwdata[drc_pkg::CHAN_DIG_LSB +: 8];
				end
				default: ;
			endcase
		end
	end

	// ==========================================================
	// capacity computation
	logic [31:0] rate;
	logic [47:0] den0;
	logic [47:0] den1;
	logic [47:0] num;
	logic div_busy;
	logic div_job;
	logic [5:0] div_cnt;
	logic [47:0] div_num;
	logic [47:0] div_den;
	logic [48:0] div_rem;
	logic [48:0] rem_sh;
	logic div_ge;
	logic [47:0] next_num;

	// samples per second and per recording
	always_comb begin
		rate = 32'(drc_pkg::FN_HZ) * (32'(ana_n) + 32'h1) * (32'h40 >> ctrl.rate)
			+ 32'(drc_pkg::DIG_HZ) * 32'(dig_n);
		den0 = 48'(rate);
		den1 = 48'(rate) * 48'(len_ms);
		num = 48'(MEM_WORDS) * 48'h3E8;
		rem_sh = {div_rem[47:0], div_num[47]};
		div_ge = rem_sh >= {1'b0, div_den};
		next_num = {div_num[46:0], div_ge};
	end

	assign max_pre = (max_len < drc_pkg::PRE_MAX) ? max_len : drc_pkg::PRE_MAX;

	// shared restoring divider, alternating between max length and max count
	always_ff @(posedge clk or negedge rst_n_s) begin
		if (!rst_n_s) begin
			div_busy <= 1'b0;
			div_job <= 1'b0;
			div_cnt <= 6'h00;
			div_num <= 48'h0;
			div_den <= 48'h1;
			div_rem <= 49'h0;
			max_len <= 32'h0000_0000;
			max_num <= 7'h00;
		end else if (!div_busy) begin
			div_busy <= 1'b1;
			div_cnt <= 6'h00;
			div_num <= num;
			div_rem <= 49'h0;
			div_den <= div_job ? den1 : den0;
		end else begin
			div_rem <= div_ge ? rem_sh - {1'b0, div_den} : rem_sh;
			div_num <= next_num;
			div_cnt <= div_cnt + 6'h01;
			if (div_cnt == 6'h2F) begin
				div_busy <= 1'b0;
				div_job <= ~div_job;
				if (!div_job) begin
					max_len <= (next_num > 48'(drc_pkg::LEN_MAX)) ? drc_pkg::LEN_MAX
						: next_num[31:0];
				end else begin
					max_num <= (next_num > 48'(drc_pkg::MAX_RECS)) ? drc_pkg::MAX_RECS
						: next_num[6:0];
				end
			end
		end
	end

	// ==========================================================
	// time base
	logic [31:0] ms_cnt;
	logic ms_tick;
	logic [2:0] dig_ms;
	logic [2:0] ana_dec;

	assign ms_tick = ms_cnt == 32'(MS_CYC - 1);

	// free-running millisecond tick, 5 ms digital phase, analog decimation
	always_ff @(posedge clk or negedge rst_n_s) begin
		if (!rst_n_s) begin
			ms_cnt <= 32'h0000_0000;
			dig_ms <= 3'h0;
			ana_dec <= 3'h0;
		end else begin
			ms_cnt <= ms_tick ? 32'h0000_0000 : ms_cnt + 32'h1;
			if (ms_tick) begin
				dig_ms <= (dig_ms == drc_pkg::DIG_MS - 3'h1) ? 3'h0 : dig_ms + 3'h1;
			end
			if (ana_strobe) begin
				ana_dec <= ana_dec + 3'h1;
			end
		end
	end

	// ==========================================================
	// trigger and state machine
	drc_pkg::drc_state_t st;
	drc_pkg::drc_state_t next_st;
	drc_pkg::drc_state_t idle_st;
	logic trig_prev;
	logic trig_src;
	logic trig_any;
	logic cfg_bad;
	logic [31:0] post_ms;
	logic [31:0] post_goal;
	logic [31:0] pre_fill;
	logic [31:0] store_cnt;
	logic capturing;
	logic do_commit;

	assign trig_src = |(binary_sig & trig_sel);
	assign trig_any = man_req || (trig_src && !trig_prev);
	assign capturing = st == drc_pkg::ST_READY || st == drc_pkg::ST_TRIG
		|| st == drc_pkg::ST_RECSTORE;
	assign do_commit = st == drc_pkg::ST_STORING && store_cnt == 32'(STORE_CYC - 1);
	assign rec_state = st;

	// configuration check and resting state
	always_comb begin
		cfg_bad = trig_sel == '0 || max_len == 32'h0 || max_num == 7'h00
			|| len_ms < drc_pkg::LEN_MIN || len_ms > drc_pkg::LEN_MAX
			|| pre_ms < drc_pkg::PRE_MIN || pre_ms > drc_pkg::PRE_MAX
			|| pre_ms >= len_ms || len_ms > max_len
			|| ana_n > drc_pkg::ANA_MAX || dig_n > drc_pkg::DIG_MAX;
		if (!ctrl.enable) begin
			idle_st = drc_pkg::ST_OFF;
		end else if (cfg_bad) begin
			idle_st = drc_pkg::ST_WRONG;
		end else if (ctrl.keep && count >= max_num) begin
			idle_st = drc_pkg::ST_FULL;
		end else begin
			idle_st = drc_pkg::ST_READY;
		end
	end

	// next state
	always_comb begin
		next_st = st;
		case (st)
			drc_pkg::ST_OFF, drc_pkg::ST_FULL, drc_pkg::ST_WRONG: next_st = idle_st;
			drc_pkg::ST_READY: begin
				if (idle_st != drc_pkg::ST_READY) begin
					next_st = idle_st;
				end else if (trig_any) begin
					next_st = drc_pkg::ST_TRIG;
				end
			end
			drc_pkg::ST_TRIG, drc_pkg::ST_RECSTORE: begin
				if (ms_tick) begin
					next_st = (post_ms + 32'h1 >= post_goal) ? drc_pkg::ST_STORING
						: drc_pkg::ST_RECSTORE;
				end
			end
			drc_pkg::ST_STORING: begin
				if (do_commit) begin
					next_st = idle_st;
				end
			end
			default: next_st = drc_pkg::ST_OFF;
		endcase
	end

	// status code seen by software
	always_comb begin
		case (st)
			drc_pkg::ST_READY: st_code = 3'h0;
			drc_pkg::ST_TRIG: st_code = 3'h1;
			drc_pkg::ST_RECSTORE: st_code = 3'h2;
			drc_pkg::ST_STORING: st_code = 3'h3;
			drc_pkg::ST_FULL: st_code = 3'h4;
			drc_pkg::ST_WRONG: st_code = 3'h5;
			default: st_code = 3'h6;
		endcase
	end

	// state, capture timers and pre-trigger fill
	always_ff @(posedge clk or negedge rst_n_s) begin
		if (!rst_n_s) begin
			st <= drc_pkg::ST_OFF;
			trig_prev <= 1'b0;
			post_ms <= 32'h0;
			post_goal <= 32'h0;
			pre_fill <= 32'h0;
			store_cnt <= 32'h0;
		end else begin
			st <= next_st;
			trig_prev <= trig_src;
			if (st == drc_pkg::ST_READY && next_st == drc_pkg::ST_TRIG) begin
				post_ms <= 32'h0;
				post_goal <= len_ms - pre_ms;
			end else if (ms_tick) begin
				post_ms <= post_ms + 32'h1;
			end
			if (st != drc_pkg::ST_READY) begin
				pre_fill <= 32'h0;
			end else if (ms_tick && pre_fill < pre_ms) begin
				pre_fill <= pre_fill + 32'h1;
			end
			store_cnt <= (st == drc_pkg::ST_STORING && !do_commit) ? store_cnt + 32'h1 : 32'h0;
		end
	end

	// sample strobes towards the capture memory
	always_ff @(posedge clk or negedge rst_n_s) begin
		if (!rst_n_s) begin
			ana_take <= 1'b0;
			dig_take <= 1'b0;
			pre_full <= 1'b0;
		end else begin
			ana_take <= capturing && ana_strobe
				&& (ana_dec & ((3'h1 << ctrl.rate) - 3'h1)) == 3'h0;
			dig_take <= capturing && ms_tick && dig_ms == drc_pkg::DIG_MS - 3'h1;
			pre_full <= st == drc_pkg::ST_READY && pre_fill >= pre_ms;
		end
	end

	// ==========================================================
	// commands and store bookkeeping
	logic [15:0] seq_mem [0:drc_pkg::MAX_RECS-1];
	logic [15:0] next_seq;
	logic room;
	logic do_store;
	logic do_drop;
	logic do_all;
	logic do_new;
	logic do_old;
	logic do_idx;
	logic idx_ok;
	logic del_en;
	logic [6:0] del_k;
	logic [6:0] wr_slot;

	assign room = count < max_num;
	assign do_store = do_commit && (room || !ctrl.keep);
	assign do_drop = do_store && !room && count != 7'h00;
	assign do_all = pend_all && !do_commit;
	assign do_new = pend_new && !pend_all && !do_commit;
	assign do_old = pend_old && !pend_all && !pend_new && !do_commit;
	assign do_idx = pend_idx && !pend_all && !pend_new && !pend_old && !do_commit;
	assign idx_ok = clr_idx != 32'h0 && clr_idx <= 32'(count);
	assign del_k = do_idx ? clr_idx[6:0] - 7'h01 : 7'h00;
	assign del_en = do_drop || (do_old && count != 7'h00) || (do_idx && idx_ok);
	assign wr_slot = do_drop ? count - 7'h01 : count;

	// command pending bits; a new write wins over the clearing
	always_ff @(posedge clk or negedge rst_n_s) begin
		if (!rst_n_s) begin
			man_req <= 1'b0;
			pend_all <= 1'b0;
			pend_new <= 1'b0;
			pend_old <= 1'b0;
			pend_idx <= 1'b0;
		end else begin
			man_req <= wr_cmd && pwdata[drc_pkg::CMD_MANUAL];
			pend_all <= (pend_all && !do_all) || (wr_cmd && pwdata[drc_pkg::CMD_CLR_ALL]);
			pend_new <= (pend_new && !do_new) || (wr_cmd && pwdata[drc_pkg::CMD_CLR_NEW]);
			pend_old <= (pend_old && !do_old) || (wr_cmd && pwdata[drc_pkg::CMD_CLR_OLD]);
			pend_idx <= (pend_idx && !do_idx) || (wr_en && paddr == drc_pkg::OFF_CLR_IDX);
		end
	end

	// recording count and commit report
	always_ff @(posedge clk or negedge rst_n_s) begin
		if (!rst_n_s) begin
			count <= 7'h00;
			next_seq <= 16'h0000;
			commit <= '0;
		end else begin
			commit <= '0;
			if (do_store) begin
				next_seq <= next_seq + 16'h0001;
				commit <= {1'b1, do_drop, wr_slot, next_seq};
				if (!do_drop && count < drc_pkg::MAX_RECS) begin
					count <= count + 7'h01;
				end
			end else if (do_all) begin
				count <= 7'h00;
			end else if ((do_new && count != 7'h00) || (del_en && !do_drop)) begin
				count <= count - 7'h01;
			end
		end
	end

	// recording list, oldest at slot 0; a delete closes the gap
	always_ff @(posedge clk) begin
		for (int i = 0; i < int'(drc_pkg::MAX_RECS) - 1; i++) begin
			if (del_en && 7'(i) >= del_k) begin
				seq_mem[i] <= seq_mem[i+1];
			end
		end
		if (do_store && wr_slot < drc_pkg::MAX_RECS) begin
			seq_mem[wr_slot] <= next_seq;
		end
	end

	// ==========================================================
	// assertions
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n_s);

	count_cap_a: assert property (count <= drc_pkg::MAX_RECS && max_num <= drc_pkg::MAX_RECS)
		else $error("recording count above limit");
	start_src_a: assert property (st == drc_pkg::ST_READY && trig_any && idle_st == drc_pkg::ST_READY
		|=> st == drc_pkg::ST_TRIG)
		else $error("trigger did not start capture");
	off_start_a: assert property (!ctrl.enable && st != drc_pkg::ST_READY
		|=> st != drc_pkg::ST_TRIG)
		else $error("capture started while disabled");
	manual_back_a: assert property (man_req && !wr_cmd |=> !man_req)
		else $error("manual command did not revert");
	clear_all_a: assert property (do_all |=> count == 7'h00)
		else $error("clear all left recordings");
	clear_new_a: assert property (do_new && count != 7'h00 |=> count == $past(count) - 7'h01)
		else $error("clear newest wrong count");
	clear_old_a: assert property (do_old && count > 7'h01 |=> seq_mem[0] == $past(seq_mem[1]))
		else $error("clear oldest removed wrong entry");
	clear_idx_a: assert property (do_idx && idx_ok |=> count == $past(count) - 7'h01)
		else $error("indexed clear wrong count");
	ready_ok_a: assert property (st == drc_pkg::ST_READY |-> max_len != 32'h0 && trig_sel != '0)
		else $error("ready with invalid setup");
	keep_refuse_a: assert property (do_commit && ctrl.keep && !room |=> !commit.valid && $stable(count))
		else $error("keep mode stored when full");
	fifo_drop_a: assert property (do_commit && !ctrl.keep && !room && count != 7'h00
		|=> commit.dropped && $stable(count))
		else $error("overwrite did not replace oldest");
	dig_rate_a: assert property (dig_take |=> !dig_take [*8])
		else $error("digital samples too close");

	capture_c: cover property (st == drc_pkg::ST_TRIG ##[1:1000] st == drc_pkg::ST_STORING);
	commit_c: cover property (commit.valid);
	overwrite_c: cover property (commit.valid && commit.dropped);
	clr_idx_c: cover property (do_idx && idx_ok);

endmodule

`default_nettype wire

//--- hdl/drc_top_unused_note.sv
`default_nettype none
`default_nettype wire

//--- testbench/drc_meas.sv
// measurement side model: one strobe per analog sample at 64 s/c
// assumes the bench clock and the active low bench reset
`default_nettype none

module drc_meas #(
	parameter int PER = 4
) (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// sample strobe
	output logic ana_strobe
);
	timeunit 1ns;
	timeprecision 1ps;
	int cnt;

	// ==========================================================
	// strobe generator
	// one-cycle strobe every PER cycles, low between strobes
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cnt <= 0;
			ana_strobe <= 1'b0;
		end else begin
			cnt <= (cnt == PER - 1) ? 0 : cnt + 1;
			ana_strobe <= (cnt == 0);
		end
	end
endmodule

`default_nettype wire

//--- testbench/tb.sv
// self-checking bench of the recorder control over apb
// assumes the short ms count, a small memory and a strobe every 4 cycles
`default_nettype none

module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rstn, psel, penable, pwrite, pready, pslverr, slv;
	logic ana_strobe, ana_take, dig_take, pre_full, last_drop;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd, binary_sig;
	drc_pkg::drc_commit_t commit;
	drc_pkg::drc_state_t rec_state;
	int err_count = 0;
	int comparisons = 0;
	int n_ana = 0;
	int n_dig = 0;
	int n_com = 0;

	// ==========================================================
	// design and measurement model
	drc_top #(.NSIG(32), .MS_CYC(10), .MEM_WORDS(2000), .STORE_CYC(16)) i_dut (
		.clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .binary_sig(binary_sig), .ana_strobe(ana_strobe),
		.ana_take(ana_take), .dig_take(dig_take), .pre_full(pre_full),
		.commit(commit), .rec_state(rec_state));
	drc_meas #(.PER(4)) i_meas (.clk(clk), .rstn(rstn), .ana_strobe(ana_strobe));

	// clock at 250 MHz
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// counts of sample pulses and commits
	always @(posedge clk) begin
		if (ana_take === 1'b1) n_ana <= n_ana + 1;
		if (dig_take === 1'b1) n_dig <= n_dig + 1;
		if (commit.valid === 1'b1) begin
			n_com <= n_com + 1;
			last_drop <= commit.dropped;
		end
	end

	// ==========================================================
	// shared tasks
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// one apb transfer, held until pready at an access edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		rd = prdata;
		slv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000);
		check(rd, exp);
	endtask

	task automatic wst(input drc_pkg::drc_state_t s, input int n);
		for (int i = 0; i < n && rec_state !== s; i++) @(negedge clk);
		check({25'h0, rec_state}, {25'h0, s});
	endtask

	// one capture, manual or by a selected signal, timed to its commit
	task automatic cap(input logic man);
		int c0;
		int k;
		c0 = n_com;
		if (man) wr(drc_pkg::OFF_CMD, 32'h0000_0001);
		else begin
			@(posedge clk);
			binary_sig <= 32'h8000_0000;
		end
		wst(drc_pkg::ST_TRIG, 8);
		for (k = 0; k < 2000 && n_com == c0; k++) @(negedge clk);
		check(32'(k >= 1000 && k <= 1040), 32'h0000_0001);
		@(posedge clk);
		binary_sig <= 32'h0000_0000;
	endtask

	task automatic summarize();
		$display("errors %0d comparisons %0d", err_count, comparisons);
		if (err_count == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// ==========================================================
	// scenarios
	task automatic t_reset();
		rdc(drc_pkg::OFF_REC_LEN, drc_pkg::LEN_DEF);
		rdc(drc_pkg::OFF_PRE_LEN, drc_pkg::PRE_DEF);
		rdc(drc_pkg::OFF_CTRL, 32'h0000_0000);
		check({25'h0, rec_state}, {25'h0, drc_pkg::ST_OFF});
		apb(1'b0, 8'h3C, 32'h0000_0000);
		check({31'h0, slv}, 32'h0000_0001);
	endtask

	task automatic t_config();
		wr(drc_pkg::OFF_REC_LEN, 32'h0000_012C);
		wr(drc_pkg::OFF_CTRL, 32'h0000_0001);
		wst(drc_pkg::ST_WRONG, 300);
		rdc(drc_pkg::OFF_STATUS, 32'h0000_0005);
		wr(drc_pkg::OFF_TRIG_SEL, 32'h8000_0001);
		wst(drc_pkg::ST_READY, 300);
		rdc(drc_pkg::OFF_STATUS, 32'h0000_0000);
		rdc(drc_pkg::OFF_MAX_NUM, 32'h0000_0002);
		rdc(drc_pkg::OFF_MAX_LEN, 32'h0000_0271);
		rdc(drc_pkg::OFF_MAX_PRE, 32'h0000_0271);
		wr(drc_pkg::OFF_CHAN_CNT, 32'h0000_0001);
		repeat (200) @(posedge clk);
		rdc(drc_pkg::OFF_MAX_NUM, 32'h0000_0001);
		wr(drc_pkg::OFF_CHAN_CNT, 32'h0000_0000);
		wr(drc_pkg::OFF_REC_LEN, 32'h0000_0063);
		wst(drc_pkg::ST_WRONG, 300);
		wr(drc_pkg::OFF_REC_LEN, 32'h0000_012C);
		wr(drc_pkg::OFF_PRE_LEN, 32'h0000_00C7);
		wst(drc_pkg::ST_WRONG, 300);
		wr(drc_pkg::OFF_PRE_LEN, 32'h0000_00C8);
		wst(drc_pkg::ST_READY, 300);
	endtask

	// every analog rate, digital pace fixed at 5 ms
	task automatic t_rates();
		int a0;
		int d0;
		for (int r = 0; r < 4; r++) begin
			wr(drc_pkg::OFF_CTRL, 32'({r[1:0], 2'b01}));
			repeat (200) @(negedge clk);
			a0 = n_ana;
			d0 = n_dig;
			repeat (500) @(negedge clk);
			a0 = n_ana - a0 - (125 >> r);
			d0 = n_dig - d0 - 10;
			check(32'(a0 >= -1 && a0 <= 1), 32'h0000_0001);
			check(32'(d0 >= -1 && d0 <= 1), 32'h0000_0001);
		end
		wr(drc_pkg::OFF_CTRL, 32'h0000_0001);
		for (int i = 0; i < 2500 && pre_full !== 1'b1; i++) @(negedge clk);
		check({31'h0, pre_full}, 32'h0000_0001);
	endtask

	task automatic t_capture();
		cap(1'b1);
		rdc(drc_pkg::OFF_CMD, 32'h0000_0000);
		rdc(drc_pkg::OFF_REC_CNT, 32'h0000_0001);
		@(posedge clk);
		binary_sig <= 32'h0000_0002;
		repeat (20) @(negedge clk);
		check({25'h0, rec_state}, {25'h0, drc_pkg::ST_READY});
		cap(1'b0);
		rdc(drc_pkg::OFF_REC_CNT, 32'h0000_0002);
		cap(1'b1);
		check({31'h0, last_drop}, 32'h0000_0001);
		rdc(drc_pkg::OFF_REC_CNT, 32'h0000_0002);
	endtask

	task automatic t_clears();
		wr(drc_pkg::OFF_CMD, 32'h0000_0004);
		rdc(drc_pkg::OFF_REC_CNT, 32'h0000_0001);
		cap(1'b1);
		wr(drc_pkg::OFF_CMD, 32'h0000_0008);
		rdc(drc_pkg::OFF_REC_CNT, 32'h0000_0001);
		wr(drc_pkg::OFF_CLR_IDX, 32'h0000_0005);
		rdc(drc_pkg::OFF_REC_CNT, 32'h0000_0001);
		wr(drc_pkg::OFF_CLR_IDX, 32'h0000_0001);
		rdc(drc_pkg::OFF_REC_CNT, 32'h0000_0000);
		cap(1'b1);
		cap(1'b0);
		wr(drc_pkg::OFF_CMD, 32'h0000_0002);
		rdc(drc_pkg::OFF_REC_CNT, 32'h0000_0000);
	endtask

	// keep mode refuses a capture ending on full memory and any new one, then switch off
	task automatic t_keep_off();
		int c0;
		cap(1'b1);
		cap(1'b1);
		c0 = n_com;
		wr(drc_pkg::OFF_CMD, 32'h0000_0001);
		wst(drc_pkg::ST_TRIG, 8);
		wr(drc_pkg::OFF_CTRL, 32'h0000_0003);
		wst(drc_pkg::ST_FULL, 1200);
		check(n_com, c0);
		rdc(drc_pkg::OFF_REC_CNT, 32'h0000_0002);
		rdc(drc_pkg::OFF_STATUS, 32'h0000_0004);
		wr(drc_pkg::OFF_CMD, 32'h0000_0001);
		repeat (1200) @(negedge clk);
		check(n_com, c0);
		wr(drc_pkg::OFF_CTRL, 32'h0000_0000);
		wst(drc_pkg::ST_OFF, 50);
		@(posedge clk);
		binary_sig <= 32'h8000_0000;
		repeat (30) @(negedge clk);
		check({25'h0, rec_state}, {25'h0, drc_pkg::ST_OFF});
	endtask

	// ==========================================================
	// main sequence and watchdog
	initial begin
		rstn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		binary_sig = 32'h0000_0000;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		repeat (3) @(posedge clk);
		t_reset();
		t_config();
		t_rates();
		t_capture();
		t_clears();
		t_keep_off();
		summarize();
	end

	initial begin
		#300000;
		err_count++;
		summarize();
	end
endmodule

`default_nettype wire
